// [design/power_state_and_watchdog.sv]
// Power sequencing, power-on reset, self-test status gating and watchdog
// Overview of operation
// - Rising key with battery: reset, enter normal
// - Key input qualified by a stability timer
// - Key high enables pre-regulator and host supplies; sensor supply unless sensor-off bit set
// - Key low, hold clear: sleep; hold set: prepare
// - Key high in sleep wakes with reset
// - After reset outputs off, registers at defaults
// - Self-test bit six isolates status, allows writes
// - Without self-test host only clears status bits
// - Leaving self-test restores status defaults, reconnects faults
// - Watchdog reset clears the self-test bit
// - Refresh reloads interval and restarts count
// - Expiry without refresh pulses host reset low
// - Any reset: watchdog enabled, ten seconds
// - Count field clamps to range one to ten
// - Unit bits one second, 100ms, 10ms; largest wins
// - Configuration bit seven enables the watchdog
// - Service bit seven write reloads the timer
// - Nonzero service value loads once, else configuration
// - Service register cleared on each timer load
// - Host reset held after supply good, reasserted on faults
// - Internal reset bit restores defaults, reset pin untouched
// - Drivers disabled while host reset low
module power_state_and_watchdog #(
	parameter int KEY_QUAL_CYC = pswd_pkg::KEY_QUAL_CYC,
	parameter int RST_HOLD_CYC = pswd_pkg::RST_HOLD_CYC,
	parameter int TICK_CYC = pswd_pkg::TICK_CYC
) (
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic i_battery_supply_pin,
	input wire logic i_ignition_key_input,
	input wire logic i_host_supply_ok,
	input wire logic i_host_supply_uv,
	input wire logic i_battery_ov,
	input wire logic i_host_reset_out_in,
	input wire logic i_cfg_wr,
	input wire logic [7:0] i_cfg_wdata,
	input wire logic i_svc_wr,
	input wire logic [7:0] i_svc_wdata,
	input wire logic i_ctrl1_wr,
	input wire logic [7:0] i_ctrl1_wdata,
	input wire logic i_stat_wr,
	input wire logic [7:0] i_stat_wdata,
	input wire logic [7:0] i_fault_set,
	output logic [7:0] o_cfg_rdata,
	output logic [7:0] o_svc_rdata,
	output logic [7:0] o_ctrl1_rdata,
	output logic [7:0] o_stat_rdata,
	output logic [1:0] o_power_state,
	output logic o_pre_reg_en,
	output logic o_host_supply_en,
	output logic o_sensor_supply_en,
	output logic o_battery_switch_output,
	output logic o_drivers_en,
	output logic o_open_load_en,
	output logic o_regs_reset,
	output logic o_host_reset_out_o,
	output logic o_host_reset_out_oe_n
);

	localparam int KQ_W = $clog2(KEY_QUAL_CYC + 1);
	localparam int RH_W = $clog2(RST_HOLD_CYC + 1);

	pswd_pkg::power_state_t state_q;
	pswd_pkg::power_state_t state_d;

	logic [KQ_W-1:0] key_cnt_q;
	logic key_qual_q;
	logic por_q;
	logic int_reset;
	logic wd_expire;
	logic reg_rst;
	logic load_pend_q;
	logic refresh;
	logic wd_load;
	logic [6:0] wd_load_val;
	logic [pswd_pkg::TICKS_W-1:0] wd_ticks;
	logic wd_run;
	logic [7:0] cfg_q;
	logic [6:0] svc_q;
	logic [7:0] ctrl1_q;
	logic [7:0] stat_q;
	logic self_test;
	logic rst_asserted_q;
	logic [RH_W-1:0] hold_cnt_q;
	logic rst_cause;

	// Interval in 1 ms ticks from a seven-bit count and unit value
	function automatic logic [pswd_pkg::TICKS_W-1:0] interval_ticks(input logic [6:0] v);
		logic [3:0] cnt;
		logic [pswd_pkg::TICKS_W-1:0] unit;
		logic [pswd_pkg::TICKS_W+3:0] prod;
		cnt = v[3:0];
		if (cnt == 4'h0) begin
			cnt = pswd_pkg::WD_COUNT_MIN;
		end else if (cnt > pswd_pkg::WD_COUNT_MAX) begin
			cnt = pswd_pkg::WD_COUNT_MAX;
		end
		if (v[pswd_pkg::WD_UNIT_1S_BIT]) begin
			unit = 14'h03e8;
		end else if (v[pswd_pkg::WD_UNIT_100MS_BIT]) begin
			unit = 14'h0064;
		end else if (v[pswd_pkg::WD_UNIT_10MS_BIT]) begin
			unit = 14'h000a;
		end else begin
			unit = 14'h0001;
		end
		prod = unit * cnt;
		return prod[pswd_pkg::TICKS_W-1:0];
	endfunction : interval_ticks

	// Key qualification: level must persist before it is believed
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			key_cnt_q <= '0;
			key_qual_q <= 1'b0;
		end else if (i_ignition_key_input == key_qual_q) begin
			key_cnt_q <= '0;
		end else if (key_cnt_q == KQ_W'(KEY_QUAL_CYC - 1)) begin
			key_cnt_q <= '0;
			key_qual_q <= i_ignition_key_input;
		end else begin
			key_cnt_q <= key_cnt_q + KQ_W'(1);
		end
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			pswd_pkg::ST_SLEEP: begin
				if (key_qual_q && i_battery_supply_pin) begin
					state_d = pswd_pkg::ST_NORMAL;
				end
			end
			pswd_pkg::ST_NORMAL: begin
				if (!key_qual_q) begin
					if (ctrl1_q[pswd_pkg::CTRL1_POWER_HOLD_BIT]) begin
						state_d = pswd_pkg::ST_PREP_SHUTDOWN;
					end else begin
						state_d = pswd_pkg::ST_SLEEP;
					end
				end
			end
			pswd_pkg::ST_PREP_SHUTDOWN: begin
				if (key_qual_q) begin
					state_d = pswd_pkg::ST_NORMAL;
				end else if (!ctrl1_q[pswd_pkg::CTRL1_POWER_HOLD_BIT]) begin
					state_d = pswd_pkg::ST_SLEEP;
				end
			end
			default: begin
				state_d = pswd_pkg::ST_SLEEP;
			end
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			state_q <= pswd_pkg::ST_SLEEP;
		end else begin
			state_q <= state_d;
		end
	end

	// Power-on reset pulse on each wake from sleep
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			por_q <= 1'b0;
		end else begin
			por_q <= (state_q == pswd_pkg::ST_SLEEP) && (state_d == pswd_pkg::ST_NORMAL);
		end
	end

	assign int_reset = i_ctrl1_wr && i_ctrl1_wdata[pswd_pkg::CTRL1_INT_RESET_BIT];
	assign reg_rst = por_q || int_reset || wd_expire;
	assign self_test = ctrl1_q[pswd_pkg::CTRL1_SELF_TEST_BIT];

	always_ff @(posedge i_core_clk) begin
		if (i_srst || reg_rst) begin
			ctrl1_q <= pswd_pkg::CTRL1_RST;
		end else if (i_ctrl1_wr) begin
			ctrl1_q <= i_ctrl1_wdata;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst || reg_rst || rst_asserted_q) begin
			cfg_q <= pswd_pkg::WD_CFG_RST;
		end else if (i_cfg_wr) begin
			cfg_q <= i_cfg_wdata;
		end
	end

	// Status bits: fault-set and host-clear, or fully host-owned in self-test
	always_ff @(posedge i_core_clk) begin
		if (i_srst || reg_rst) begin
			stat_q <= pswd_pkg::STAT_RST;
		end else if (i_ctrl1_wr && self_test && !i_ctrl1_wdata[pswd_pkg::CTRL1_SELF_TEST_BIT]) begin
			stat_q <= pswd_pkg::STAT_RST;
		end else if (self_test) begin
			if (i_stat_wr) begin
				stat_q <= i_stat_wdata & pswd_pkg::STAT_IMPL_MASK;
			end
		end else if (i_stat_wr) begin
			stat_q <= ((stat_q & i_stat_wdata) | i_fault_set) & pswd_pkg::STAT_IMPL_MASK;
		end else begin
			stat_q <= (stat_q | i_fault_set) & pswd_pkg::STAT_IMPL_MASK;
		end
	end

	// Watchdog service and reload
	assign refresh = i_svc_wr && i_svc_wdata[pswd_pkg::WD_REFRESH_BIT];
	assign wd_load = refresh || load_pend_q;

	always_comb begin
		if (refresh && i_svc_wdata[6:0] != 7'h00) begin
			wd_load_val = i_svc_wdata[6:0];
		end else if (!load_pend_q && svc_q != 7'h00) begin
			wd_load_val = svc_q;
		end else begin
			wd_load_val = cfg_q[6:0];
		end
	end

	assign wd_ticks = interval_ticks(wd_load_val);

	always_ff @(posedge i_core_clk) begin
		if (i_srst || reg_rst) begin
			svc_q <= pswd_pkg::WD_SVC_RST;
		end else if (wd_load) begin
			svc_q <= pswd_pkg::WD_SVC_RST;
		end else if (i_svc_wr) begin
			svc_q <= i_svc_wdata[6:0];
		end
	end

	// After any register reset the timer reloads from the default interval
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			load_pend_q <= 1'b1;
		end else begin
			load_pend_q <= reg_rst || rst_asserted_q;
		end
	end

	assign wd_run = cfg_q[pswd_pkg::WD_ENABLE_BIT] && !rst_asserted_q
		&& (state_q != pswd_pkg::ST_SLEEP);

	wd_interval_timer #(
		.TICK_CYC(TICK_CYC)
	) u_wd_timer (
		.i_core_clk(i_core_clk),
		.i_srst(i_srst),
		.i_load(wd_load),
		.i_ticks(wd_ticks),
		.i_run(wd_run),
		.o_expire(wd_expire)
	);

	// Host reset: held low until supply good plus hold time, re-armed by faults
	assign rst_cause = (state_q == pswd_pkg::ST_SLEEP) || !i_host_supply_ok
		|| i_host_supply_uv || i_battery_ov || wd_expire;

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			rst_asserted_q <= 1'b1;
			hold_cnt_q <= RH_W'(RST_HOLD_CYC);
		end else if (rst_cause) begin
			rst_asserted_q <= 1'b1;
			hold_cnt_q <= RH_W'(RST_HOLD_CYC);
		end else if (hold_cnt_q != '0) begin
			hold_cnt_q <= hold_cnt_q - RH_W'(1);
		end else begin
			rst_asserted_q <= 1'b0;
		end
	end

	// Registered outputs
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_pre_reg_en <= 1'b0;
			o_host_supply_en <= 1'b0;
			o_sensor_supply_en <= 1'b0;
			o_battery_switch_output <= 1'b0;
			o_power_state <= 2'(pswd_pkg::ST_SLEEP);
		end else begin
			o_pre_reg_en <= state_q != pswd_pkg::ST_SLEEP;
			o_host_supply_en <= state_q != pswd_pkg::ST_SLEEP;
			o_sensor_supply_en <= (state_q != pswd_pkg::ST_SLEEP)
				&& !ctrl1_q[pswd_pkg::CTRL1_SENSOR_OFF_BIT];
			o_battery_switch_output <= state_q == pswd_pkg::ST_NORMAL;
			o_power_state <= 2'(state_q);
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_drivers_en <= 1'b0;
			o_open_load_en <= 1'b0;
			o_regs_reset <= 1'b0;
		end else begin
			o_drivers_en <= (state_q != pswd_pkg::ST_SLEEP) && !rst_asserted_q
				&& i_host_reset_out_in && !reg_rst;
			o_open_load_en <= (state_q != pswd_pkg::ST_SLEEP)
				&& ctrl1_q[pswd_pkg::CTRL1_OPEN_LOAD_EN_BIT];
			o_regs_reset <= reg_rst;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_host_reset_out_o <= 1'b0;
			o_host_reset_out_oe_n <= 1'b0;
		end else begin
			o_host_reset_out_o <= 1'b0;
			o_host_reset_out_oe_n <= !(rst_cause || rst_asserted_q);
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_cfg_rdata <= pswd_pkg::WD_CFG_RST;
			o_svc_rdata <= 8'h00;
			o_ctrl1_rdata <= pswd_pkg::CTRL1_RST;
			o_stat_rdata <= pswd_pkg::STAT_RST;
		end else begin
			o_cfg_rdata <= cfg_q;
			o_svc_rdata <= {1'b0, svc_q};
			o_ctrl1_rdata <= ctrl1_q;
			o_stat_rdata <= stat_q;
		end
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_srst);

	sequence s_wake;
		state_q == pswd_pkg::ST_SLEEP && key_qual_q && i_battery_supply_pin;
	endsequence

	sequence s_por_then_normal;
		por_q && state_q == pswd_pkg::ST_NORMAL ##1 ctrl1_q == pswd_pkg::CTRL1_RST;
	endsequence

	a_wake_por_normal: assert property (s_wake |=> s_por_then_normal)
		else $error("wake from sleep did not reset into normal");

	a_key_qualified: assert property ($rose(key_qual_q) |-> $past(i_ignition_key_input, 1)
		&& $past(i_ignition_key_input, 2))
		else $error("key level taken without qualification");

	a_supplies_on: assert property (state_q == pswd_pkg::ST_NORMAL |=> o_pre_reg_en
		&& o_host_supply_en && o_battery_switch_output)
		else $error("supplies not enabled in normal state");

	a_sleep_all_off: assert property (state_q == pswd_pkg::ST_SLEEP |=> !o_pre_reg_en
		&& !o_sensor_supply_en && !o_battery_switch_output && !o_drivers_en)
		else $error("sleep left something on");

	a_hold_keeps_prep: assert property (state_q == pswd_pkg::ST_NORMAL && !key_qual_q
		&& ctrl1_q[pswd_pkg::CTRL1_POWER_HOLD_BIT] |=> state_q == pswd_pkg::ST_PREP_SHUTDOWN)
		else $error("power hold did not keep supplies");

	a_stat_no_set: assert property (!self_test && i_fault_set == 8'h00 && !reg_rst
		|=> (stat_q & ~$past(stat_q)) == 8'h00)
		else $error("status bit set without fault");

	a_stat_selftest_wr: assert property (self_test && i_stat_wr && !i_ctrl1_wr && !reg_rst
		|=> stat_q == ($past(i_stat_wdata) & pswd_pkg::STAT_IMPL_MASK))
		else $error("self-test status write not stored");

	a_selftest_exit: assert property (self_test && i_ctrl1_wr
		&& !i_ctrl1_wdata[pswd_pkg::CTRL1_SELF_TEST_BIT] |=> stat_q == pswd_pkg::STAT_RST)
		else $error("status not restored on self-test exit");

	a_wd_expire_defaults: assert property (wd_expire |=> !self_test
		&& cfg_q == pswd_pkg::WD_CFG_RST && rst_asserted_q)
		else $error("watchdog expiry did not restore defaults");

	a_refresh_clears: assert property (refresh && !reg_rst |=> svc_q == 7'h00)
		else $error("service register not cleared on load");

	a_int_reset_pin: assert property (int_reset && !rst_cause |=> ctrl1_q == pswd_pkg::CTRL1_RST
		&& rst_asserted_q == $past(rst_asserted_q))
		else $error("internal reset touched the host reset");

	a_drivers_off_rst: assert property (rst_asserted_q |=> !o_drivers_en)
		else $error("drivers on during host reset");

	a_unit_default: assert property (wd_load && wd_load_val[6:4] == 3'h0
		|-> wd_ticks <= 14'h000a)
		else $error("unitless interval not in milliseconds");

endmodule : power_state_and_watchdog

// [design/pswd_pkg.sv]
// Shared constants and types for the power-state and watchdog block
package pswd_pkg;

	typedef enum logic [1:0] {
		ST_SLEEP,
		ST_NORMAL,
		ST_PREP_SHUTDOWN
	} power_state_t;

	localparam int CLK_PERIOD_NS = 10;

	// Key qualification: key must stay at one level this long before it counts
	localparam int KEY_QUAL_NS = 20000;
	localparam int KEY_QUAL_CYC = (KEY_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Host reset low time after the host supply is good, or after a timeout
	localparam int RST_HOLD_NS = 5000000;
	localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Watchdog timebase tick, the 1 ms unit
	localparam int TICK_NS = 1000000;
	localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;

	localparam int TICKS_W = 14;

	// Watchdog configuration byte
	localparam int WD_ENABLE_BIT = 7;
	localparam int WD_UNIT_1S_BIT = 6;
	localparam int WD_UNIT_100MS_BIT = 5;
	localparam int WD_UNIT_10MS_BIT = 4;
	localparam logic [7:0] WD_CFG_RST = 8'hca;
	localparam logic [3:0] WD_COUNT_MIN = 4'h1;
	localparam logic [3:0] WD_COUNT_MAX = 4'ha;

	// Watchdog service byte
	localparam int WD_REFRESH_BIT = 7;
	localparam logic [6:0] WD_SVC_RST = 7'h00;

	// Control register 1
	localparam int CTRL1_POWER_HOLD_BIT = 0;
	localparam int CTRL1_OPEN_LOAD_EN_BIT = 1;
	localparam int CTRL1_SENSOR_OFF_BIT = 2;
	localparam int CTRL1_SELF_TEST_BIT = 6;
	localparam int CTRL1_INT_RESET_BIT = 7;
	localparam logic [7:0] CTRL1_RST = 8'h02;

	// Status register
	localparam logic [7:0] STAT_IMPL_MASK = 8'h3f;
	localparam logic [7:0] STAT_RST = 8'h00;

endpackage : pswd_pkg

// [design/wd_interval_timer.sv]
// Watchdog countdown in timebase ticks with a load input and expiry pulse
module wd_interval_timer #(
	parameter int TICK_CYC = pswd_pkg::TICK_CYC
) (
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic i_load,
	input wire logic [pswd_pkg::TICKS_W-1:0] i_ticks,
	input wire logic i_run,
	output logic o_expire
);

	localparam int PRE_W = $clog2(TICK_CYC + 1);

	logic [PRE_W-1:0] pre_q;
	logic [pswd_pkg::TICKS_W-1:0] remain_q;
	logic tick;

	assign tick = i_run && (pre_q == PRE_W'(TICK_CYC - 1));

	// Prescaler restarts on each load so a whole first tick is counted
	always_ff @(posedge i_core_clk) begin
		if (i_srst || i_load || !i_run || tick) begin
			pre_q <= '0;
		end else begin
			pre_q <= pre_q + PRE_W'(1);
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			remain_q <= '0;
			o_expire <= 1'b0;
		end else begin
			o_expire <= 1'b0;
			if (i_load) begin
				remain_q <= i_ticks;
			end else if (tick && remain_q != '0) begin
				remain_q <= remain_q - pswd_pkg::TICKS_W'(1);
				if (remain_q == pswd_pkg::TICKS_W'(1)) begin
					o_expire <= 1'b1;
				end
			end
		end
	end

endmodule : wd_interval_timer

// [sim/host_mcu_model.sv]
// Host side model: pulled-up reset wire and periodic watchdog refresh
module host_mcu_model (
	input wire logic i_core_clk,
	input wire logic i_host_reset_out_o,
	input wire logic i_host_reset_out_oe_n,
	input wire logic i_auto_en,
	input wire logic [7:0] i_auto_period,
	input wire logic i_tb_svc_wr,
	input wire logic [7:0] i_tb_svc_wdata,
	output logic o_reset_wire,
	output logic o_svc_wr,
	output logic [7:0] o_svc_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt_q = 8'h00;
	logic auto_wr = 1'b0;
	// Pull-up holds the wire high unless the device pulls it low
	assign o_reset_wire = i_host_reset_out_oe_n ? 1'b1 : i_host_reset_out_o;
	always @(negedge i_core_clk) begin
		auto_wr <= 1'b0;
		if (!i_auto_en || !o_reset_wire) begin
			cnt_q <= 8'h00;
		end else if (cnt_q == i_auto_period) begin
			cnt_q <= 8'h00;
			auto_wr <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 8'h01;
		end
	end
	assign o_svc_wr = i_tb_svc_wr | auto_wr;
	assign o_svc_wdata = auto_wr ? 8'h80 : i_tb_svc_wdata;
endmodule : host_mcu_model

// [sim/power_state_and_watchdog_tb.sv]
// Self-checking bench for the power-state and watchdog block
module power_state_and_watchdog_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int KQ = 4;
	localparam int RH = 10;
	localparam int TK = 5;
	localparam logic [7:0] WCFG [6] = '{8'h80, 8'h8f, 8'h83, 8'h92, 8'hb1, 8'hf1};
	localparam int WTK [6] = '{1, 10, 3, 20, 100, 1000};
	logic i_core_clk = 1'b0;
	logic i_srst = 1'b1;
	logic key = 1'b0;
	logic sok = 1'b0;
	logic uv = 1'b0;
	logic bat = 1'b1;
	logic ov = 1'b0;
	logic auto_en = 1'b0;
	logic [3:0] wr_en = 4'h0;
	logic [7:0] wd [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0] fault = 8'h00;
	wire logic [7:0] rb [4];
	wire logic [1:0] ps;
	wire logic pre, hse, sen, bsw, drv, ole, rst_o, rst_oe_n, rst_wire, svc_wr, rrs;
	wire logic [7:0] svc_wd;
	logic [15:0] exp_q [$];
	logic [15:0] res_q [$];
	logic [15:0] res;
	logic [15:0] e;
	int n_put = 0;
	int n_fail = 0;
	int checks = 0;
	int cyc = 0;
	int lows = 0;
	int rr = 0;
	always #5 i_core_clk = ~i_core_clk;
	power_state_and_watchdog #(.KEY_QUAL_CYC(KQ), .RST_HOLD_CYC(RH), .TICK_CYC(TK)) u_power_state_and_watchdog (
		.i_core_clk(i_core_clk), .i_srst(i_srst), .i_battery_supply_pin(bat),
		.i_ignition_key_input(key), .i_host_supply_ok(sok), .i_host_supply_uv(uv),
		.i_battery_ov(ov), .i_host_reset_out_in(rst_wire),
		.i_cfg_wr(wr_en[0]), .i_cfg_wdata(wd[0]), .i_svc_wr(svc_wr), .i_svc_wdata(svc_wd),
		.i_ctrl1_wr(wr_en[2]), .i_ctrl1_wdata(wd[2]), .i_stat_wr(wr_en[3]),
		.i_stat_wdata(wd[3]), .i_fault_set(fault), .o_cfg_rdata(rb[0]), .o_svc_rdata(rb[1]),
		.o_ctrl1_rdata(rb[2]), .o_stat_rdata(rb[3]), .o_power_state(ps), .o_pre_reg_en(pre),
		.o_host_supply_en(hse), .o_sensor_supply_en(sen), .o_battery_switch_output(bsw),
		.o_drivers_en(drv), .o_open_load_en(ole), .o_regs_reset(rrs),
		.o_host_reset_out_o(rst_o), .o_host_reset_out_oe_n(rst_oe_n));
	host_mcu_model u_host_mcu_model (
		.i_core_clk(i_core_clk), .i_host_reset_out_o(rst_o), .i_host_reset_out_oe_n(rst_oe_n),
		.i_auto_en(auto_en), .i_auto_period(8'h0c), .i_tb_svc_wr(wr_en[1]),
		.i_tb_svc_wdata(wd[1]), .o_reset_wire(rst_wire), .o_svc_wr(svc_wr),
		.o_svc_wdata(svc_wd));
	task automatic stop_test();
		// Let the watcher drain results noted in this time step
		#1;
		if (n_fail == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [15:0] x, input logic [15:0] r);
		exp_q.push_back(x);
		res_q.push_back(r);
		n_put++;
	endtask : chk
	// Watcher pairs each presented result with the oldest expectation
	always begin
		wait (n_put > checks);
		e = exp_q.pop_front();
		res = res_q.pop_front();
		checks++;
		if (res !== e) begin
			n_fail++;
			$display("unexpected at %0t: expected %h got %h", $time, e, res);
		end
	end
	always @(posedge i_core_clk) begin
		cyc++;
		if (!rst_wire)
			lows++;
		if (rrs)
			rr++;
		if (cyc == 60000) begin
			n_fail++;
			stop_test();
		end
	end
	task automatic wr(input int s, input logic [7:0] d);
		wd[s] = d;
		wr_en[s] = 1'b1;
		@(negedge i_core_clk);
		wr_en[s] = 1'b0;
		repeat (2) @(negedge i_core_clk);
	endtask : wr
	task automatic wait_for(input logic v, output int n);
		n = 0;
		while (rst_wire !== v && n < 20000) begin
			@(negedge i_core_clk);
			n++;
		end
		if (n >= 20000) begin
			n_fail++;
			stop_test();
		end
	endtask : wait_for
	task automatic go_st(input pswd_pkg::power_state_t s);
		for (int i = 0; i < 50 && ps !== s; i++)
			@(negedge i_core_clk);
		chk(16'(s), 16'(ps));
	endtask : go_st
	task automatic pulse_fault(input logic [7:0] f);
		fault = f;
		@(negedge i_core_clk);
		fault = 8'h00;
		repeat (3) @(negedge i_core_clk);
	endtask : pulse_fault
	initial begin
		int n;
		logic [7:0] w;
		n = $urandom(32'h0a46);
		repeat (3) @(negedge i_core_clk);
		i_srst = 1'b0;
		chk(16'(pswd_pkg::WD_CFG_RST), 16'(rb[0]));
		chk(16'h0, 16'(rb[1]));
		chk(16'(pswd_pkg::CTRL1_RST), 16'(rb[2]));
		chk(16'(pswd_pkg::STAT_RST), 16'(rb[3]));
		chk(16'h0, 16'({pre, hse, sen, bsw, drv, rst_wire}));
		key = 1'b1;
		repeat (KQ - 2) @(negedge i_core_clk);
		key = 1'b0;
		repeat (10) @(negedge i_core_clk);
		chk(16'(pswd_pkg::ST_SLEEP), 16'(ps));
		bat = 1'b0;
		key = 1'b1;
		repeat (10) @(negedge i_core_clk);
		chk(16'(pswd_pkg::ST_SLEEP), 16'(ps));
		bat = 1'b1;
		go_st(pswd_pkg::ST_NORMAL);
		chk(16'h1f, 16'({pre, hse, sen, bsw, ole}));
		chk(16'h0, 16'(drv));
		sok = 1'b1;
		wait_for(1'b1, n);
		chk(16'h1, 16'(n >= RH - 2 && n <= RH + 4));
		for (int k = 0; k < 6; k++) begin
			wr(2, 8'h42);
			wr(0, WCFG[k]);
			wr(1, 8'h80);
			wait_for(1'b0, n);
			chk(16'h1, 16'(n + 3 >= (WTK[k] - 1) * TK && n <= WTK[k] * TK + 4));
			chk(16'h0, 16'(drv));
			wait_for(1'b1, n);
			chk(16'(pswd_pkg::WD_CFG_RST), 16'(rb[0]));
			chk(16'(pswd_pkg::CTRL1_RST), 16'(rb[2]));
		end
		wr(0, 8'h84);
		wr(1, 8'h80);
		auto_en = 1'b1;
		lows = 0;
		repeat (200) @(negedge i_core_clk);
		chk(16'h0, 16'(lows));
		auto_en = 1'b0;
		wait_for(1'b0, n);
		chk(16'h1, 16'(n + 16 >= 3 * TK && n <= 4 * TK + 4));
		wait_for(1'b1, n);
		wr(0, 8'h8a);
		wr(1, 8'h82);
		@(negedge i_core_clk);
		chk(16'h0, 16'(rb[1]));
		wait_for(1'b0, n);
		chk(16'h1, 16'(n <= 2 * TK + 4));
		wait_for(1'b1, n);
		wr(0, 8'h01);
		wr(1, 8'h80);
		lows = 0;
		repeat (100) @(negedge i_core_clk);
		chk(16'h0, 16'(lows));
		wr(0, 8'h05);
		rr = 0;
		wr(2, 8'h83);
		repeat (2) @(negedge i_core_clk);
		chk(16'h1, 16'(rr));
		chk(16'(pswd_pkg::WD_CFG_RST), 16'(rb[0]));
		chk(16'(pswd_pkg::CTRL1_RST), 16'(rb[2]));
		chk(16'h0, 16'(lows));
		pulse_fault(8'h05);
		chk(16'h05, 16'(rb[3]));
		wr(3, 8'hff);
		@(negedge i_core_clk);
		chk(16'h05, 16'(rb[3]));
		wr(3, 8'h01);
		@(negedge i_core_clk);
		chk(16'h01, 16'(rb[3]));
		wr(2, 8'h42);
		w = 8'($urandom());
		wr(3, w);
		@(negedge i_core_clk);
		chk(16'(w & 8'h3f), 16'(rb[3]));
		pulse_fault(8'hc2);
		chk(16'(w & 8'h3f), 16'(rb[3]));
		wr(2, 8'h02);
		@(negedge i_core_clk);
		chk(16'h0, 16'(rb[3]));
		pulse_fault(8'h10);
		chk(16'h10, 16'(rb[3]));
		wr(0, 8'h93);
		uv = 1'b1;
		wait_for(1'b0, n);
		chk(16'h1, 16'(n <= 3));
		uv = 1'b0;
		wait_for(1'b1, n);
		chk(16'(pswd_pkg::WD_CFG_RST), 16'(rb[0]));
		ov = 1'b1;
		wait_for(1'b0, n);
		chk(16'h1, 16'(n <= 3));
		ov = 1'b0;
		wait_for(1'b1, n);
		wr(2, 8'h07);
		key = 1'b0;
		go_st(pswd_pkg::ST_PREP_SHUTDOWN);
		chk(16'hc, 16'({pre, hse, sen, bsw}));
		key = 1'b1;
		go_st(pswd_pkg::ST_NORMAL);
		wr(2, 8'h02);
		key = 1'b0;
		go_st(pswd_pkg::ST_SLEEP);
		repeat (2) @(negedge i_core_clk);
		chk(16'h0, 16'({pre, hse, sen, bsw, drv}));
		stop_test();
	end
endmodule : power_state_and_watchdog_tb
